// File: line_driver_interface_select.v
// control interface and driver control of the dual line driver transceiver
`timescale 1ns/1ps
`include "line_drv_defs.vh"
module line_driver_interface_select #(
  parameter [31:0] WAKE_CYCLES = `WAKE_LOW_CYCLES
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       serial_mode_sel,
  input  wire       chip_select_pushpull_pin,
  input  wire       uart_pin_select,
  input  wire       line_drive_enable,
  input  wire       line_tx_in,
  input  wire       aux_output_in,
  input  wire       lamp1_input,
  input  wire       serial_in_shared,
  input  wire       serial_clock_shared,
  input  wire       line_level_in,
  input  wire       aux_input,
  input  wire       wake_detect,
  input  wire       overcurrent,
  input  wire       thermal_shutdown,
  input  wire       multiplex_mode_bit,
  input  wire       line_driver_off,
  input  wire       line_level_bit,
  input  wire       line_rx_off,
  input  wire [1:0] line_drv_mode_cfg,
  input  wire       aux_driver_off,
  input  wire       aux_level_bit,
  input  wire       aux_receiver_off,
  input  wire [1:0] aux_drv_mode_cfg,
  input  wire       irq_pending,
  input  wire       lamp1_bit,
  input  wire       lamp2_bit,
  input  wire       serial_data_out,
  input  wire       serial_data_out_oe,
  output reg        line_o,
  output reg        line_oe,
  output reg        aux_o,
  output reg        aux_oe,
  output reg        line_rx_o,
  output reg        line_rx_oe,
  output reg        aux_receive_out,
  output reg        aux_receive_oe,
  output reg        serial_out_shared,
  output reg        serial_out_shared_oe,
  output reg        wakeup_flag_out,
  output reg        interrupt_overcurrent_n,
  output reg        interrupt_overcurrent_oe,
  output reg        lamp1_out,
  output reg        lamp2_out,
  output reg        ilim_200ma,
  output reg        serial_port_active
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  wire [13:0] raw_in;
  wire [13:0] syn;
  assign raw_in = {serial_mode_sel, chip_select_pushpull_pin, uart_pin_select,
                   line_drive_enable, line_tx_in, aux_output_in, lamp1_input,
                   serial_in_shared, serial_clock_shared, line_level_in, aux_input,
                   wake_detect, overcurrent, thermal_shutdown};

  sync2 #(
    .W (14)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (raw_in),
    .q   (syn)
  );

  wire s_serial = syn[13];
  wire s_cspp   = syn[12];
  wire s_usel   = syn[11];
  wire s_line_drive_enable   = syn[10];
  wire s_tx     = syn[9];
  wire s_lo     = syn[8];
  wire s_l1in   = syn[7];
  wire s_sdi    = syn[6];
  wire s_clk    = syn[5];
  wire s_line   = syn[4];
  wire s_aux    = syn[3];
  wire s_wake   = syn[2];
  wire s_oc     = syn[1];
  wire s_thsh   = syn[0];

  // ----------------------------------------
  // uart select falling-edge sampling
  // ----------------------------------------
  reg usel_prev_q;
  reg mux_line_drive_enable_q;
  reg mux_tx_q;

  // capture shared pins on select fall
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      usel_prev_q <= `RST_LEVEL_LOW;
      mux_line_drive_enable_q  <= `RST_LEVEL_LOW;
      mux_tx_q    <= `RST_LEVEL_HIGH;
    end else begin
      usel_prev_q <= s_usel;
      if (usel_prev_q && !s_usel) begin
        mux_line_drive_enable_q <= s_clk;
        mux_tx_q   <= s_sdi;
      end
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  reg       mux_mode;
  reg       uart_shared;
  reg       drv_en_line;
  reg       tx_line;
  reg [1:0] mode_line;
  reg [1:0] mode_aux;
  reg       en_aux;
  reg       idle_line;
  reg       idle_aux;

  always @* begin
    // select only counts in serial mode
    mux_mode    = s_serial & s_usel;
    uart_shared = 1'b0;
    drv_en_line = s_line_drive_enable;
    tx_line     = s_tx;
    idle_line   = 1'b0;
    idle_aux    = 1'b0;
    en_aux      = 1'b1;
    mode_line   = line_drv_mode_cfg;
    mode_aux    = aux_drv_mode_cfg;
    if (!s_serial) begin
      // npn or pnp from shared pin
      if (s_cspp)
        mode_line = `DRV_MODE_PP;
      else if (s_sdi)
        mode_line = `DRV_MODE_NPN;
      else
        mode_line = `DRV_MODE_PNP;
      mode_aux = mode_line;
      drv_en_line = s_line_drive_enable;
      // aux driver cannot be turned off
      en_aux = 1'b1;
    end else begin
      if (mux_mode) begin
        if (multiplex_mode_bit) begin
          drv_en_line = mux_line_drive_enable_q;
          tx_line     = mux_tx_q;
          uart_shared = 1'b0;
        end else if (s_cspp) begin
          uart_shared = 1'b1;
          drv_en_line = s_clk;
          tx_line     = s_sdi;
        end else begin
          drv_en_line = s_line_drive_enable;
          tx_line     = s_sdi;
        end
      end
      // off forces tristate, level forces idle
      // level bit drives the idle state even with enable low
      if (line_level_bit)
        drv_en_line = 1'b1;
      if (line_driver_off)
        drv_en_line = 1'b0;
      idle_line = line_level_bit;
      en_aux    = ~aux_driver_off;
      idle_aux  = aux_level_bit;
    end
  end

  // ----------------------------------------
  // driver stages
  // ----------------------------------------
  wire line_o_d;
  wire line_oe_d;
  wire aux_o_d;
  wire aux_oe_d;

  drv_stage u_line (
    .mode       (mode_line),
    .enable     (drv_en_line),
    .force_idle (idle_line),
    .data_in    (tx_line),
    .pin_o      (line_o_d),
    .pin_oe     (line_oe_d)
  );

  drv_stage u_aux (
    .mode       (mode_aux),
    .enable     (en_aux),
    .force_idle (idle_aux),
    .data_in    (s_lo),
    .pin_o      (aux_o_d),
    .pin_oe     (aux_oe_d)
  );

  // ----------------------------------------
  // wake-up pulse
  // ----------------------------------------
  reg [31:0] wake_cnt_q;
  reg        wake_prev_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_cnt_q  <= 32'h0;
      wake_prev_q <= `RST_LEVEL_LOW;
    end else begin
      wake_prev_q <= s_wake;
      if (s_wake && !wake_prev_q)
        wake_cnt_q <= WAKE_CYCLES;
      else if (wake_cnt_q != 32'h0)
        wake_cnt_q <= wake_cnt_q - 32'h1;
    end
  end

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      line_o                   <= 1'b0;
      line_oe                  <= 1'b0;
      aux_o                    <= 1'b0;
      aux_oe                   <= 1'b0;
      line_rx_o                <= 1'b1;
      line_rx_oe               <= 1'b0;
      aux_receive_out          <= 1'b1;
      aux_receive_oe           <= 1'b0;
      serial_out_shared        <= 1'b1;
      serial_out_shared_oe     <= 1'b0;
      wakeup_flag_out          <= 1'b1;
      interrupt_overcurrent_n  <= 1'b0;
      interrupt_overcurrent_oe <= 1'b0;
      lamp1_out                <= 1'b0;
      lamp2_out                <= 1'b0;
      ilim_200ma               <= `ILIM_100MA;
      serial_port_active       <= 1'b0;
    end else begin
      line_o  <= line_o_d;
      line_oe <= line_oe_d;
      aux_o   <= aux_o_d;
      aux_oe  <= aux_oe_d;
      line_rx_o  <= ~s_line;
      line_rx_oe <= ~s_serial | ~line_rx_off;
      aux_receive_out <= ~s_aux;
      aux_receive_oe  <= ~s_serial | ~aux_receiver_off;
      wakeup_flag_out <= (wake_cnt_q == 32'h0);
      interrupt_overcurrent_oe <= s_serial ? irq_pending : s_oc;
      // serial access framed by chip select low
      serial_port_active <= s_serial & ~s_cspp & ~(mux_mode & multiplex_mode_bit);
      if (!s_serial) begin
        serial_out_shared    <= 1'b0;
        serial_out_shared_oe <= s_thsh;
      end else if (uart_shared) begin
        serial_out_shared    <= ~s_line;
        serial_out_shared_oe <= ~line_rx_off;
      end else begin
        serial_out_shared    <= serial_data_out;
        serial_out_shared_oe <= serial_data_out_oe & ~s_cspp;
      end
      lamp1_out <= s_serial ? lamp1_bit : s_l1in;
      lamp2_out <= lamp2_bit;
      if (!s_serial)
        ilim_200ma <= s_clk ? `ILIM_200MA : `ILIM_100MA;
    end
  end
endmodule

// File: line_drv_defs.vh
// constants of the line driver interface select block
`ifndef LINE_DRV_DEFS_VH
`define LINE_DRV_DEFS_VH

// ----------------------------------------
// driver modes
// ----------------------------------------
`define DRV_MODE_PNP      2'h0
`define DRV_MODE_NPN      2'h1
`define DRV_MODE_PP       2'h2

// ----------------------------------------
// current limit codes
// ----------------------------------------
`define ILIM_100MA        1'h0
`define ILIM_200MA        1'h1

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS     10
`define WAKE_LOW_MS       200
`define WAKE_LOW_CYCLES   ((`WAKE_LOW_MS * 1000000) / `CLK_PERIOD_NS)

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_LEVEL_LOW     1'h0
`define RST_LEVEL_HIGH    1'h1

`endif

// File: sync2.v
// two-stage synchroniser for an asynchronous level
`timescale 1ns/1ps
module sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// File: drv_stage.v
// one driver output stage: mode, enable and data to pin level and enable
`timescale 1ns/1ps
`include "line_drv_defs.vh"
module drv_stage (
  input  wire [1:0] mode,
  input  wire       enable,
  input  wire       force_idle,
  input  wire       data_in,
  output reg        pin_o,
  output reg        pin_oe
);
  reg data_eff;

  always @* begin
    data_eff = force_idle ? 1'b0 : data_in;
    pin_o    = 1'b0;
    pin_oe   = 1'b0;
    if (enable) begin
      case (mode)
        `DRV_MODE_NPN: begin
          pin_o  = 1'b0;
          pin_oe = data_eff;
        end
        `DRV_MODE_PNP: begin
          pin_o  = 1'b1;
          pin_oe = ~data_eff;
        end
        default: begin
          pin_o  = ~data_eff;
          pin_oe = 1'b1;
        end
      endcase
    end
  end
endmodule

// File: mcu_model.sv
// controller-side model: mode pins, chip select framing and link clock
`timescale 1ns/1ps
module mcu_model (
  input  logic       clk,
  input  logic [8:0] pins,
  input  logic       frame,
  output logic       serial_mode_sel,
  output logic       chip_select_pushpull_pin,
  output logic       uart_pin_select,
  output logic       line_drive_enable,
  output logic       line_tx_in,
  output logic       aux_output_in,
  output logic       lamp1_input,
  output logic       serial_in_shared,
  output logic       serial_clock_shared
);
  logic [8:0] q = 9'h0;
  logic [2:0] ph_q = 3'h0;
  assign {serial_mode_sel, chip_select_pushpull_pin, uart_pin_select, line_drive_enable,
          line_tx_in, aux_output_in, lamp1_input, serial_in_shared, serial_clock_shared} = q;
  always @(posedge clk) begin
    ph_q <= frame ? ph_q + 3'h1 : 3'h0;
    q <= pins;
    if (frame) begin
      q[7] <= 1'b0;
      // link clock runs only inside a frame, 80 ns period
      q[0] <= ph_q[2];
      q[1] <= ph_q[2] ^ ph_q[1];
    end
  end
endmodule

// File: line_driver_interface_select_properties.sv
// port-level checks of the line driver interface select block
`timescale 1ns/1ps
module line_driver_interface_select_checker #(
  parameter [31:0] WAKE_CYCLES = 32'h32
) (
  input logic       clk, rst, serial_mode_sel, chip_select_pushpull_pin, uart_pin_select,
  input logic       line_drive_enable, line_tx_in, aux_output_in, lamp1_input, serial_in_shared,
  input logic       serial_clock_shared, line_level_in, aux_input, wake_detect, overcurrent,
  input logic       thermal_shutdown, multiplex_mode_bit, line_driver_off, line_level_bit,
  input logic       line_rx_off, aux_receiver_off, irq_pending, lamp2_bit,
  input logic [1:0] line_drv_mode_cfg,
  input logic       line_o, line_oe, aux_o, aux_oe, line_rx_o, line_rx_oe, aux_receive_out,
  input logic       aux_receive_oe, serial_out_shared, serial_out_shared_oe, wakeup_flag_out,
  input logic       interrupt_overcurrent_oe, lamp1_out, lamp2_out, ilim_200ma
);
  // ----
  // settle tracking: async pins need three edges to reach the outputs
  // ----
  logic [21:0] in_q;
  logic [2:0]  calm_q;
  logic [31:0] low_q;
  wire  [21:0] in_now = {serial_mode_sel, chip_select_pushpull_pin, uart_pin_select,
    line_drive_enable, line_tx_in, aux_output_in, lamp1_input, serial_in_shared,
    serial_clock_shared, line_level_in, aux_input, overcurrent, thermal_shutdown,
    multiplex_mode_bit, line_driver_off, line_level_bit, line_rx_off, aux_receiver_off,
    irq_pending, lamp2_bit, line_drv_mode_cfg};
  wire steady = calm_q == 3'h4 && in_now == in_q;
  wire pin = steady && !serial_mode_sel;
  wire ser = steady && serial_mode_sel;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      in_q   <= 22'h0;
      calm_q <= 3'h0;
      low_q  <= 32'h0;
    end else begin
      in_q   <= in_now;
      calm_q <= (in_now != in_q) ? 3'h0 : calm_q + {2'h0, calm_q != 3'h4};
      low_q  <= wakeup_flag_out ? 32'h0 : low_q + 32'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_pin_pushpull: assert property (pin && chip_select_pushpull_pin && line_drive_enable
    |-> line_oe && line_o == !line_tx_in) else $error("push-pull line wrong");
  a_pin_disable: assert property (pin && !line_drive_enable |-> !line_oe)
    else $error("line driven while disabled");
  a_npn_mode: assert property (pin && !chip_select_pushpull_pin && serial_in_shared
    && line_drive_enable |-> line_oe == line_tx_in && !(line_oe && line_o))
    else $error("npn line wrong");
  a_aux_always_on: assert property (pin && chip_select_pushpull_pin
    |-> aux_oe && aux_o == !aux_output_in) else $error("aux output wrong");
  a_rx_invert: assert property (pin |-> line_rx_oe && line_rx_o == !line_level_in
    && aux_receive_oe && aux_receive_out == !aux_input) else $error("receive output wrong");
  a_rx_off: assert property (ser && line_rx_off && aux_receiver_off
    |-> !line_rx_oe && !aux_receive_oe) else $error("receiver not off");
  a_irq_source: assert property (steady |-> interrupt_overcurrent_oe ==
    (serial_mode_sel ? irq_pending : overcurrent)) else $error("interrupt wrong");
  a_line_off: assert property (ser && line_driver_off |-> !line_oe)
    else $error("line driven while switched off");
  a_thermal_flag: assert property (pin && thermal_shutdown
    |-> serial_out_shared_oe && !serial_out_shared) else $error("shutdown flag wrong");
  a_ilim_pick: assert property (pin |-> ilim_200ma == serial_clock_shared)
    else $error("current limit wrong");
  a_lamp_follow: assert property (steady |-> lamp2_out == lamp2_bit
    && (serial_mode_sel || lamp1_out == lamp1_input)) else $error("lamp wrong");
  a_mux_uart: assert property (ser && uart_pin_select && chip_select_pushpull_pin
    && !multiplex_mode_bit && !line_driver_off && !line_level_bit && line_drv_mode_cfg[1]
    |-> line_oe == serial_clock_shared && !(line_oe && line_o == serial_in_shared))
    else $error("mux uart line wrong");
  a_wake_start: assert property ($rose(wake_detect) |-> ##[2:4] !wakeup_flag_out)
    else $error("wake pulse late");
  a_wake_length: assert property ($rose(wakeup_flag_out) |-> low_q == WAKE_CYCLES)
    else $error("wake pulse length wrong");
  c_pin_drive: cover property (pin && line_oe);
  c_serial_frame: cover property (serial_mode_sel && !chip_select_pushpull_pin);
  c_wake: cover property ($fell(wakeup_flag_out));
endmodule
bind line_driver_interface_select line_driver_interface_select_checker #(
  .WAKE_CYCLES(WAKE_CYCLES)
) i_line_driver_interface_select_checker (.*);

// File: tb_line_driver_interface_select.sv
// self-checking bench for the line driver interface select block
`timescale 1ns/1ps
module tb_line_driver_interface_select;
  logic clk, rst, frame, wake_detect, eoe, eo;
  logic [8:0] pins;
  logic [19:0] cfg;
  logic serial_mode_sel, chip_select_pushpull_pin, uart_pin_select, line_drive_enable;
  logic line_tx_in, aux_output_in, lamp1_input, serial_in_shared, serial_clock_shared;
  logic line_level_in, aux_input, overcurrent, thermal_shutdown, irq_pending, lamp2_bit;
  logic lamp1_bit, multiplex_mode_bit, line_driver_off, line_level_bit, line_rx_off;
  logic aux_driver_off, aux_level_bit, aux_receiver_off, serial_data_out, serial_data_out_oe;
  logic [1:0] line_drv_mode_cfg, aux_drv_mode_cfg;
  logic line_o, line_oe, aux_o, aux_oe, line_rx_o, line_rx_oe, aux_receive_out, aux_receive_oe;
  logic serial_out_shared, serial_out_shared_oe, wakeup_flag_out, interrupt_overcurrent_n;
  logic interrupt_overcurrent_oe, lamp1_out, lamp2_out, ilim_200ma, serial_port_active;
  int fail_count, comparisons, cycles, m;
  assign {line_level_in, aux_input, overcurrent, thermal_shutdown, irq_pending, lamp2_bit,
          lamp1_bit, multiplex_mode_bit, line_driver_off, line_level_bit, line_rx_off,
          aux_driver_off, aux_level_bit, aux_receiver_off, serial_data_out,
          serial_data_out_oe, line_drv_mode_cfg, aux_drv_mode_cfg} = cfg;
  mcu_model i_mcu_model (.*);
  line_driver_interface_select #(.WAKE_CYCLES(32'h32)) i_line_driver_interface_select (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task drive(input logic [8:0] p, input logic [19:0] c);
    pins <= p;
    cfg <= c;
    repeat (8) @(posedge clk);
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      end_of_test;
    end
  end
  initial begin
    {rst, frame, wake_detect, pins, cfg} = {3'h4, 29'h0};
    {fail_count, comparisons, cycles} = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // pin mode driver table: m[2] push-pull, m[1] npn pick, m[0] transmit
    for (m = 0; m < 8; m++) begin
      drive({1'b0, m[2], 2'h1, m[0], m[0], 1'b0, m[1], 1'b0}, 20'h0);
      eoe = m[2] | (m[1] ~^ m[0]);
      eo = !m[0];
      chk({line_oe, line_oe & line_o, aux_oe, aux_oe & aux_o}, {2{eoe, eoe & eo}});
    end
    drive(9'h080, 20'h0);
    chk({line_oe, aux_oe, aux_o, 1'b0}, 4'h6);
    drive(9'h0c5, 20'hb4000);
    chk({line_rx_o, aux_receive_out, interrupt_overcurrent_oe, ilim_200ma}, 4'h7);
    chk({serial_out_shared_oe, serial_out_shared, lamp1_out, lamp2_out}, 4'hb);
    drive(9'h080, 20'h40000);
    chk({line_rx_o, aux_receive_out, lamp1_out, ilim_200ma}, 4'h8);
    // parallel serial mode with push-pull stages, except a pnp line stage in the last level check
    drive(9'h1b0, 20'h0000a);
    chk({line_oe, line_o, 2'h0}, 4'h8);
    drive(9'h1a0, 20'h0000a);
    chk({line_oe, line_o, 2'h0}, 4'hc);
    drive(9'h1a0, 20'h0090a);
    chk({line_oe, aux_oe, 2'h0}, 4'h0);
    drive(9'h1b0, 20'h0040a);
    chk({line_oe, line_o, 2'h0}, 4'hc);
    drive(9'h188, 20'h00482);
    chk({line_oe, line_o, aux_oe, aux_o}, 4'hf);
    drive(9'h180, 20'h0c24a);
    chk({line_rx_oe, aux_receive_oe, interrupt_overcurrent_oe, lamp2_out}, 4'h3);
    frame <= 1'b1;
    drive(9'h180, 20'h0003a);
    chk({serial_out_shared, serial_out_shared_oe, interrupt_overcurrent_n,
         serial_port_active}, 4'hd);
    frame <= 1'b0;
    drive(9'h180, 20'h0003a);
    chk({serial_out_shared, serial_out_shared_oe, interrupt_overcurrent_n,
         serial_port_active}, 4'h8);
    // multiplexed mode, chip select high then low
    drive(9'h1d1, 20'h0000a);
    chk({line_oe, line_o, serial_out_shared_oe, serial_out_shared}, 4'hf);
    drive(9'h1d0, 20'h0000a);
    chk({line_oe, 3'h0}, 4'h0);
    drive(9'h1d3, 20'h0000a);
    chk({line_oe, line_o, 2'h0}, 4'h8);
    drive(9'h162, 20'h0000a);
    chk({line_oe, line_o, 2'h0}, 4'h8);
    drive(9'h142, 20'h0000a);
    chk({line_oe, 3'h0}, 4'h0);
    // mux bit set: pins latched at select fall drive the line
    drive(9'h181, 20'h0100a);
    drive(9'h1c2, 20'h0100a);
    chk({line_oe, line_o, 2'h0}, 4'hc);
    wake_detect <= 1'b1;
    repeat (5) @(posedge clk);
    chk({3'h0, wakeup_flag_out}, 4'h0);
    repeat (55) @(posedge clk);
    chk({3'h0, wakeup_flag_out}, 4'h1);
    end_of_test;
  end
endmodule
